// ===== design/bbf_host.sv
// Purpose : Host controller sequencing commands into a boot-block flash
// Assumes : Software register port; one flash operation at a time
// Notes   : Polls the device status word until the automaton reports ready
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
module bbf_host
  import bbf_pkg::*;
#(
  parameter int RECOVER_CYCLES = (WAKE_CYC > OUTV_CYC) ? WAKE_CYC : OUTV_CYC,
  parameter int RESET_CYCLES   = RST_CYC
)(
  input  wire logic        clk_sys,            // System clock
  input  wire logic        resetn,             // Sync reset, active low
  input  wire logic [3:0]  reg_addr,           // Register index
  input  wire logic [31:0] reg_wdata,          // Register write data
  input  wire logic        reg_wr,             // Write strobe
  input  wire logic        reg_rd,             // Read strobe
  output logic [31:0]      reg_rdata,          // Read data, cycle after reg_rd
  output logic [bbf_pkg::ADDR_W-1:0] flash_addr, // Flash word address
  input  wire logic [15:0] flash_dq_in,        // Flash data in
  output logic [15:0]      flash_dq_out,       // Flash data out
  output logic             flash_dq_oe_n,      // Low while driving data
  output logic             flash_ce_n,         // Chip enable
  output logic             flash_oe_n,         // Output enable
  output logic             flash_we_n,         // Write strobe
  output logic             flash_rp_n,         // Reset/power-down pin
  input  wire logic        program_supply_low, // Program supply at lockout
  output logic             busy                // Sequence in progress
);
  import bbf_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (RECOVER_CYCLES < 1 || RECOVER_CYCLES > 65535) begin : g_bad_recover
    $error("RECOVER_CYCLES out of range");
  end
  if (RESET_CYCLES < 1 || RESET_CYCLES > 65535) begin : g_bad_reset
    $error("RESET_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Operation alters array or lock bits
  function automatic logic is_alter(input logic [3:0] op);
    return (op >= OP_WRITE) && (op <= OP_CLRLOCK);
  endfunction

  // Setup command word of a sequence; writes read the old word first
  function automatic logic [15:0] setup_word(input logic [3:0] op);
    case (op)
      OP_WRITE:   setup_word = DC_WRITE;
      OP_BERASE:  setup_word = DC_ERASE;
      OP_CERASE:  setup_word = DC_CHIP_ERASE;
      OP_SUSPEND: setup_word = DC_SUSPEND;
      OP_RESUME:  setup_word = DC_RESUME;
      default:    setup_word = DC_LOCK_SETUP;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [10:0] {
    S_RST    = 11'b00000000001,
    S_WAKE   = 11'b00000000010,
    S_IDLE   = 11'b00000000100,
    S_OLDCMD = 11'b00000001000,
    S_OLDRD  = 11'b00000010000,
    S_SETUP  = 11'b00000100000,
    S_CONF   = 11'b00001000000,
    S_PCMD   = 11'b00010000000,
    S_PRD    = 11'b00100000000,
    S_RDCMD  = 11'b01000000000,
    S_RDARR  = 11'b10000000000
  } bbf_state_type;

  bbf_cyc_if cyc ();

  bbf_state_type state, next_state;
  logic [15:0]   cnt, next_cnt;
  logic [3:0]    op, next_op, run_op, next_run_op;
  logic [18:0]   addr_q, next_addr_q;
  logic [15:0]   wdata_q, next_wdata_q, old_q, next_old_q;
  logic [15:0]   rdata_q, next_rdata_q, dev_status, next_dev_status;
  logic          susp, next_susp, susp_wr, next_susp_wr;
  logic          refused, next_refused, pend, next_pend;
  logic          start;
  logic [3:0]    sw_op;
  logic [15:0]   prog_word;

  assign start     = reg_wr && (reg_addr == REG_CTRL);
  assign sw_op     = reg_wdata[3:0];
  assign prog_word = ~old_q | wdata_q;  // Zero only where a one becomes zero
  assign busy      = (state != S_IDLE);

  // Cycle request derived from state
  always_comb begin
    cyc.req   = (state & (S_OLDCMD | S_OLDRD | S_SETUP | S_CONF | S_PCMD | S_PRD
                          | S_RDCMD | S_RDARR)) != 11'b0;
    cyc.wr    = (state & (S_OLDCMD | S_SETUP | S_CONF | S_PCMD | S_RDCMD)) != 11'b0;
    cyc.addr  = addr_q;
    cyc.wdata = DC_READ_ARRAY;
    case (state)
      S_SETUP: cyc.wdata = setup_word(op);
      S_CONF: begin
        case (op)
          OP_WRITE:   cyc.wdata = prog_word;
          OP_SETLOCK: cyc.wdata = DC_SET_LOCK;
          OP_SETPERM: cyc.wdata = DC_SET_PERM;
          default:    cyc.wdata = DC_CONFIRM;  // Erase and clear-locks confirm
        endcase
      end
      S_PCMD:  cyc.wdata = DC_READ_STAT;
      default: cyc.wdata = DC_READ_ARRAY;
    endcase
  end

  // Next sequencer values
  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_op         = op;
    next_run_op     = run_op;
    next_addr_q     = addr_q;
    next_wdata_q    = wdata_q;
    next_old_q      = old_q;
    next_rdata_q    = rdata_q;
    next_dev_status = dev_status;
    next_susp       = susp;
    next_susp_wr    = susp_wr;
    next_refused    = refused;
    next_pend       = pend;
    if (reg_wr && reg_addr == REG_ADDR) next_addr_q = reg_wdata[18:0];
    if (reg_wr && reg_addr == REG_DATA) next_wdata_q = reg_wdata[15:0];
    if (reg_wr && reg_addr == REG_STAT && reg_wdata[ST_REFUSED]) next_refused = 1'b0;
    // While busy only a reset, or a suspend of block erase or word write, is taken
    if (start && state != S_IDLE) begin
      if (sw_op == OP_SUSPEND && !susp && op != OP_SUSPEND
          && (run_op == OP_BERASE || run_op == OP_WRITE)) next_pend = 1'b1;
      else if (sw_op != OP_RESET) next_refused = 1'b1;
    end
    if (start && sw_op == OP_RESET) begin
      next_state = S_RST;               // Hold device in reset, writes ignored
      next_cnt   = 16'(RESET_CYCLES - 1);
      next_susp  = 1'b0;
      next_pend  = 1'b0;
    end else begin
      case (state)
        S_RST: begin
          if (cnt == 16'h0000) begin
            next_state = S_WAKE;
            next_cnt   = 16'(RECOVER_CYCLES - 1);
          end else next_cnt = cnt - 16'h0001;
        end
        S_WAKE: begin
          // No command write or read sample before recovery
          if (cnt == 16'h0000) next_state = S_IDLE;  // Device back in read array
          else next_cnt = cnt - 16'h0001;
        end
        S_IDLE: begin
          if (start) begin
            next_op = sw_op;
            // Lockout supply refuses altering operations
            if (is_alter(sw_op) && program_supply_low) next_refused = 1'b1;
            else if (susp && !(sw_op == OP_READ || sw_op == OP_STATUS
                     || sw_op == OP_RESUME || (sw_op == OP_WRITE && !susp_wr)))
              next_refused = 1'b1;      // Suspended: limited set
            else if (!susp && sw_op == OP_RESUME) next_refused = 1'b1;
            else if (sw_op == OP_SUSPEND || sw_op > OP_STATUS) next_refused = 1'b1;
            else begin
              case (sw_op)
                OP_READ:   next_state = S_RDCMD;
                OP_STATUS: next_state = S_PCMD;
                OP_WRITE:  next_state = S_OLDCMD;
                OP_RESUME: next_state = S_SETUP;
                default:   next_state = S_SETUP;
              endcase
              if (sw_op == OP_RESUME) next_susp = 1'b0;
              else if (is_alter(sw_op) && !susp) next_run_op = sw_op;
            end
          end
        end
        S_OLDCMD: if (cyc.done) next_state = S_OLDRD;
        S_OLDRD: begin
          if (cyc.done) begin
            next_old_q = cyc.rdata;
            next_state = S_SETUP;
          end
        end
        S_SETUP: begin
          if (cyc.done) begin
            if (op == OP_SUSPEND || op == OP_RESUME) next_state = S_PCMD;
            else next_state = S_CONF;
          end
        end
        S_CONF:  if (cyc.done) next_state = S_PCMD;  // Device runs alone now
        S_PCMD:  if (cyc.done) next_state = S_PRD;
        S_PRD: begin
          if (cyc.done) begin
            next_dev_status = cyc.rdata;            // Completion seen here
            if (op == OP_STATUS) next_state = S_IDLE;
            else if (cyc.rdata[DEV_READY_BIT]) begin
              next_state = S_IDLE;
              if (op == OP_SUSPEND) begin
                next_susp    = 1'b1;
                next_susp_wr = (run_op == OP_WRITE);
              end
            end else if (pend) begin
              next_pend  = 1'b0;
              next_op    = OP_SUSPEND;
              next_state = S_SETUP;
            end
          end
        end
        S_RDCMD: if (cyc.done) next_state = S_RDARR;
        S_RDARR: begin
          if (cyc.done) begin
            next_rdata_q = cyc.rdata;
            next_state   = S_IDLE;
          end
        end
        default: next_state = S_IDLE;
      endcase
    end
    if (next_state == S_IDLE && next_op != OP_SUSPEND && state != S_IDLE) next_pend = 1'b0;
    if (start && state != S_IDLE && sw_op != OP_SUSPEND && sw_op != OP_RESET)
      next_refused = 1'b1;            // Hardware set wins over software clear
  end

  // Register sequencer state
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state      <= S_RST;
      cnt        <= 16'(RESET_CYCLES - 1);
      op         <= OP_READ;
      run_op     <= OP_READ;
      addr_q     <= 19'h00000;
      wdata_q    <= 16'hFFFF;
      old_q      <= 16'hFFFF;
      rdata_q    <= 16'h0000;
      dev_status <= 16'h0000;
      susp       <= 1'b0;
      susp_wr    <= 1'b0;
      refused    <= 1'b0;
      pend       <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      op         <= next_op;
      run_op     <= next_run_op;
      addr_q     <= next_addr_q;
      wdata_q    <= next_wdata_q;
      old_q      <= next_old_q;
      rdata_q    <= next_rdata_q;
      dev_status <= next_dev_status;
      susp       <= next_susp;
      susp_wr    <= next_susp_wr;
      refused    <= next_refused;
      pend       <= next_pend;
    end
  end

  // Reset pin low only in the reset state
  always_ff @(posedge clk_sys) begin
    if (!resetn) flash_rp_n <= 1'b0;
    else flash_rp_n <= (next_state != S_RST);
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) reg_rdata <= 32'h00000000;
    else if (reg_rd) begin
      case (reg_addr)
        REG_ADDR:  reg_rdata <= {13'h0000, addr_q};
        REG_DATA:  reg_rdata <= {16'h0000, wdata_q};
        REG_STAT:  reg_rdata <= {10'h000, pend, program_supply_low, refused, susp_wr,
                                 susp, busy, dev_status};
        REG_RDATA: reg_rdata <= {16'h0000, rdata_q};
        default:   reg_rdata <= 32'h00000000;
      endcase
    end else reg_rdata <= 32'h00000000;
  end

  // ----------------------------------------------------------------
  // Bus cycle engine
  // ----------------------------------------------------------------
  bbf_cycle u_cycle (
    .clk_sys       (clk_sys),
    .resetn        (resetn),
    .cyc           (cyc.eng),
    .flash_addr    (flash_addr),
    .flash_dq_in   (flash_dq_in),
    .flash_dq_out  (flash_dq_out),
    .flash_dq_oe_n (flash_dq_oe_n),
    .flash_ce_n    (flash_ce_n),
    .flash_oe_n    (flash_oe_n),
    .flash_we_n    (flash_we_n)
  );
endmodule

// ===== design/bbf_pkg.sv
// Purpose : Constants for the host-side controller of a 512K x 16 boot-block flash
// Assumes : clk_sys at 250 MHz; the flash sits on an asynchronous parallel bus
// Notes   : What this block does
package bbf_pkg;

  // ----------------------------------------------------------------
  // Widths and geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 19;   // 512K words
  localparam int DATA_W     = 16;
  localparam int NUM_BLOCKS = 23;

  // ----------------------------------------------------------------
  // Timing, in ns and derived clock cycles
  // ----------------------------------------------------------------
  localparam int CLK_NS          = 4;
  localparam int T_ACCESS_NS     = 100;  // Address to output valid
  localparam int T_SETUP_NS      = 20;   // Address/data before write strobe
  localparam int T_PULSE_NS      = 50;   // Write strobe low time
  localparam int T_HOLD_NS       = 10;   // Hold after strobe rises
  localparam int T_RESET_LOW_NS  = 100;  // Reset pin low time
  localparam int T_WAKE_NS       = 1000; // Reset to write wake time
  localparam int T_OUT_VALID_NS  = 600;  // Reset to output valid time
  localparam int ACC_CYC   = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC  = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC   = (T_RESET_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_CYC  = (T_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int OUTV_CYC  = (T_OUT_VALID_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // Software register indexes and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL  = 4'h0;  // Write: start operation
  localparam logic [3:0] REG_ADDR  = 4'h1;
  localparam logic [3:0] REG_DATA  = 4'h2;
  localparam logic [3:0] REG_STAT  = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam int ST_BUSY    = 16;
  localparam int ST_SUSP    = 17;
  localparam int ST_SUSP_WR = 18;
  localparam int ST_REFUSED = 19;
  localparam int ST_LOCKOUT = 20;
  localparam int ST_PEND    = 21;

  // ----------------------------------------------------------------
  // Operation codes written to REG_CTRL
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_READ    = 4'h0;
  localparam logic [3:0] OP_WRITE   = 4'h1;
  localparam logic [3:0] OP_BERASE  = 4'h2;
  localparam logic [3:0] OP_CERASE  = 4'h3;
  localparam logic [3:0] OP_SETLOCK = 4'h4;
  localparam logic [3:0] OP_SETPERM = 4'h5;
  localparam logic [3:0] OP_CLRLOCK = 4'h6;
  localparam logic [3:0] OP_SUSPEND = 4'h7;
  localparam logic [3:0] OP_RESUME  = 4'h8;
  localparam logic [3:0] OP_STATUS  = 4'h9;
  localparam logic [3:0] OP_RESET   = 4'hA;

  // ----------------------------------------------------------------
  // Device command words and status bit
  // ----------------------------------------------------------------
  localparam logic [15:0] DC_READ_ARRAY = 16'h00FF;
  localparam logic [15:0] DC_READ_STAT  = 16'h0070;
  localparam logic [15:0] DC_WRITE      = 16'h0040;
  localparam logic [15:0] DC_ERASE      = 16'h0020;
  localparam logic [15:0] DC_CHIP_ERASE = 16'h0030;
  localparam logic [15:0] DC_LOCK_SETUP = 16'h0060;
  localparam logic [15:0] DC_CONFIRM    = 16'h00D0;
  localparam logic [15:0] DC_SET_LOCK   = 16'h0001;
  localparam logic [15:0] DC_SET_PERM   = 16'h00F1;
  localparam logic [15:0] DC_SUSPEND    = 16'h00B0;
  localparam logic [15:0] DC_RESUME     = 16'h00D0;
  localparam int DEV_READY_BIT = 7;

endpackage

// ===== design/bbf_cyc_if.sv
// Purpose : Carries one bus-cycle request from sequencer to cycle engine
// Assumes : One cycle outstanding at a time
// Notes   : done is a one-cycle pulse, rdata valid with it
`timescale 1ns/10ps
interface bbf_cyc_if;
  logic        req;    // Level, held until done
  logic        wr;     // 1 write cycle, 0 read cycle
  logic [18:0] addr;
  logic [15:0] wdata;
  logic        done;   // Pulse, cycle finished
  logic [15:0] rdata;  // Sampled read word

  modport seq (output req, wr, addr, wdata, input done, rdata);
  modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface

// ===== design/bbf_cycle.sv
// Purpose : Runs one asynchronous write or read cycle on the flash pins
// Assumes : Flash inputs synchronous to clk_sys
// Notes   : Strobes and data come from flip-flops
`timescale 1ns/10ps
module bbf_cycle
  import bbf_pkg::*;
(
  input  wire logic        clk_sys,       // System clock
  input  wire logic        resetn,        // Sync reset, active low
  bbf_cyc_if.eng           cyc,           // Cycle request
  output logic [18:0]      flash_addr,    // Word address
  input  wire logic [15:0] flash_dq_in,   // Data from flash
  output logic [15:0]      flash_dq_out,  // Data to flash
  output logic             flash_dq_oe_n, // Low while driving data
  output logic             flash_ce_n,    // Chip enable
  output logic             flash_oe_n,    // Output enable
  output logic             flash_we_n     // Write strobe
);
  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    C_IDLE  = 5'b00001,
    C_SETUP = 5'b00010,
    C_PULSE = 5'b00100,
    C_HOLD  = 5'b01000,
    C_READ  = 5'b10000
  } bbf_cstate_type;

  bbf_cstate_type cstate, next_cstate;
  logic [7:0]     cnt, next_cnt;
  logic [18:0]    next_addr;
  logic [15:0]    next_dq_out, next_rdata;
  logic           next_dq_oe_n, next_ce_n, next_oe_n, next_we_n, next_done;

  // Next cycle-engine values
  always_comb begin
    next_cstate  = cstate;
    next_cnt     = cnt;
    next_addr    = flash_addr;
    next_dq_out  = flash_dq_out;
    next_dq_oe_n = flash_dq_oe_n;
    next_ce_n    = flash_ce_n;
    next_oe_n    = flash_oe_n;
    next_we_n    = flash_we_n;
    next_rdata   = cyc.rdata;
    next_done    = 1'b0;
    case (cstate)
      C_IDLE: begin
        if (cyc.req && !cyc.done) begin
          next_addr = cyc.addr;
          next_ce_n = 1'b0;
          if (cyc.wr) begin
            next_dq_out  = cyc.wdata;
            next_dq_oe_n = 1'b0;
            next_cnt     = 8'(SETUP_CYC - 1);
            next_cstate  = C_SETUP;
          end else begin
            next_oe_n   = 1'b0;
            next_cnt    = 8'(ACC_CYC - 1);
            next_cstate = C_READ;
          end
        end
      end
      C_SETUP: begin
        if (cnt == 8'h00) begin
          next_we_n   = 1'b0;
          next_cnt    = 8'(PULSE_CYC - 1);
          next_cstate = C_PULSE;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      C_PULSE: begin
        if (cnt == 8'h00) begin
          next_we_n   = 1'b1;               // Rising edge latches addr/data
          next_cnt    = 8'(HOLD_CYC - 1);
          next_cstate = C_HOLD;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      C_HOLD: begin
        if (cnt == 8'h00) begin
          next_ce_n    = 1'b1;
          next_dq_oe_n = 1'b1;
          next_done    = 1'b1;
          next_cstate  = C_IDLE;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      C_READ: begin
        if (cnt == 8'h00) begin
          next_rdata  = flash_dq_in;       // Sampled after full access time
          next_ce_n   = 1'b1;
          next_oe_n   = 1'b1;
          next_done   = 1'b1;
          next_cstate = C_IDLE;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      default: next_cstate = C_IDLE;
    endcase
  end

  // Register cycle-engine state
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cstate        <= C_IDLE;
      cnt           <= 8'h00;
      flash_addr    <= 19'h00000;
      flash_dq_out  <= 16'h0000;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      cyc.rdata     <= 16'h0000;
      cyc.done      <= 1'b0;
    end else begin
      cstate        <= next_cstate;
      cnt           <= next_cnt;
      flash_addr    <= next_addr;
      flash_dq_out  <= next_dq_out;
      flash_dq_oe_n <= next_dq_oe_n;
      flash_ce_n    <= next_ce_n;
      flash_oe_n    <= next_oe_n;
      flash_we_n    <= next_we_n;
      cyc.rdata     <= next_rdata;
      cyc.done      <= next_done;
    end
  end
endmodule

// ===== tb/bbf_host_chk.sv
// Purpose : Pin timing checks for bbf_host
// Assumes : Bench sets RESET_CYCLES to 2
// Notes   : up counts cycles since the reset pin rose
`timescale 1ns/10ps
module bbf_host_chk #(parameter int RECOVER_CYCLES = 4) (
  input wire logic        clk_sys, resetn, reg_rd, flash_rp_n, // Clock, reset, pins
  input wire logic        flash_ce_n, flash_oe_n, flash_we_n,  // Strobes
  input wire logic        flash_dq_oe_n,                       // Data drive
  input wire logic [31:0] reg_rdata,                           // Read data
  input wire logic [18:0] flash_addr                           // Address
);
  int up;
  // Cycles since reset pin high
  always_ff @(posedge clk_sys) up <= flash_rp_n ? up + (up < 999) : 0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_rst; disable iff (1'b0) !resetn |=> !flash_rp_n && flash_we_n; endproperty
  a_rst: assert property (p_rst) else $error("pins not safe in reset");
  property p_wake; !flash_we_n |-> up >= RECOVER_CYCLES; endproperty
  a_wake: assert property (p_wake) else $error("write before wake");
  property p_outv; !flash_oe_n |-> up >= RECOVER_CYCLES - 1; endproperty
  a_outv: assert property (p_outv) else $error("read before valid");
  property p_rpl; $fell(flash_rp_n) |-> !flash_rp_n [*2]; endproperty
  a_rpl: assert property (p_rpl) else $error("reset pulse short");
  property p_wep; $fell(flash_we_n) |-> !flash_we_n [*8] ##1 !flash_we_n [*5] ##1 flash_we_n;
  endproperty
  a_wep: assert property (p_wep) else $error("strobe width");
  property p_weq; !flash_we_n |-> !flash_ce_n && !flash_dq_oe_n && flash_oe_n; endproperty
  a_weq: assert property (p_weq) else $error("strobe qualifiers");
  property p_su; $fell(flash_we_n) |-> $past(flash_ce_n, 4) == 1'b0; endproperty
  a_su: assert property (p_su) else $error("setup short");
  property p_hd; $rose(flash_we_n) |-> (!flash_dq_oe_n && $stable(flash_addr)) [*3]; endproperty
  a_hd: assert property (p_hd) else $error("hold short");
  property p_rd; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
endmodule
bind bbf_host bbf_host_chk #(.RECOVER_CYCLES(RECOVER_CYCLES)) i_bbf_host_chk (
  .clk_sys(clk_sys), .resetn(resetn), .reg_rd(reg_rd), .flash_rp_n(flash_rp_n),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_dq_oe_n(flash_dq_oe_n), .reg_rdata(reg_rdata), .flash_addr(flash_addr));

// ===== tb/bbf_flash_model.sv
// Purpose : Behavioural boot-block flash
// Assumes : Status ready on the third poll
// Notes   : Released bus shows the inverted word
`timescale 1ns/10ps
module bbf_flash_model
  import bbf_pkg::*;
(
  input  wire logic [18:0] a,                  // Word address
  input  wire logic [15:0] d,                  // Bus level
  output logic      [15:0] q,                  // Data out
  input  wire logic        ce_n, oe_n, we_n, rp_n // Strobes, reset pin
);
  logic [15:0] mem [logic [18:0]];
  logic [15:0] cmd = DC_READ_ARRAY, v = 16'h0;
  logic [22:0] lk = '0; // Block lock bits
  logic        perm = 1'b0; // Permanent lock bit
  int          poll = 0;
  // Fifteen main, eight small blocks
  function automatic int blk(logic [18:0] x);
    return (x[18:15] == 4'hF) ? 15 + x[14:12] : x[18:15];
  endfunction
  // Erased words read ones
  function automatic logic [15:0] rd(logic [18:0] x);
    return mem.exists(x) ? mem[x] : 16'hFFFF;
  endfunction
  // Reset pin clears automaton
  always @(negedge rp_n) cmd = DC_READ_ARRAY;
  // Latch on strobe rise
  always @(posedge we_n) if (rp_n && !ce_n) begin
    if (cmd == DC_WRITE && !lk[blk(a)]) mem[a] = (~rd(a) & ~d) ? 16'h0BAD : rd(a) & d;
    if (d == DC_CONFIRM && cmd inside {DC_ERASE, DC_CHIP_ERASE})
      foreach (mem[k]) if (!lk[blk(k)] && (cmd == DC_CHIP_ERASE || blk(k) == blk(a))) mem[k] = '1;
    if (cmd == DC_LOCK_SETUP && !perm)
      lk = (d == DC_CONFIRM) ? '0 : lk | (23'(d == DC_SET_LOCK) << blk(a));
    if (cmd == DC_LOCK_SETUP && d == DC_SET_PERM) perm = 1'b1;
    if (cmd inside {DC_WRITE, DC_ERASE, DC_CHIP_ERASE, DC_LOCK_SETUP} || d inside {DC_SUSPEND, DC_CONFIRM}) poll = 2;
    cmd = (cmd inside {DC_WRITE, DC_ERASE, DC_CHIP_ERASE, DC_LOCK_SETUP}) ? DC_READ_STAT : d;
  end
  // Read word or status
  always @(negedge oe_n) #1 v = (cmd == DC_READ_ARRAY) ? rd(a) : 16'(poll == 0) << DEV_READY_BIT;
  always @(posedge oe_n) if (poll > 0) poll--;
  assign q = (!ce_n && !oe_n && rp_n) ? v : ~v;
endmodule

// ===== tb/bbf_host_tb.sv
// Purpose : Self-checking bench for bbf_host
// Assumes : Short reset and recovery counts
// Notes   : Flash model on the pins
`timescale 1ns/10ps
module bbf_host_tb;
  import bbf_pkg::*;
  logic        clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0, supply_low = 0, busy;
  logic [3:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [18:0] fa;
  logic [15:0] fq, fd;
  logic        dq_oe_n, ce_n, oe_n, we_n, rp_n;
  wire  [15:0] dq = !dq_oe_n ? fd : fq; // Resolved data bus
  int          err_count = 0, checks = 0;
  initial forever #2 clk_sys = ~clk_sys;
  bbf_host #(.RECOVER_CYCLES(4), .RESET_CYCLES(2)) i_bbf_host (.clk_sys(clk_sys),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(fa), .flash_dq_in(dq),
    .flash_dq_out(fd), .flash_dq_oe_n(dq_oe_n), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_rp_n(rp_n), .program_supply_low(supply_low), .busy(busy));
  bbf_flash_model i_bbf_flash_model (.a(fa), .d(dq), .q(fq), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .rp_n(rp_n));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task automatic rx(input logic [3:0] a, input logic [31:0] m, e);
    @(posedge clk_sys);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic idle();
    repeat (3) @(posedge clk_sys) #1;
    for (int i = 0; busy !== 1'b0; i++) begin
      if (i > 9000) begin
        err_count++;
        report_and_stop();
      end
      @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic run(input logic [31:0] a, d, input logic [3:0] o);
    wr(REG_ADDR, a);
    wr(REG_DATA, d);
    wr(REG_CTRL, {28'h0, o});
    idle();
  endtask
  task automatic rb(input logic [31:0] a, e);
    run(a, 0, OP_READ);
    rx(REG_RDATA, 32'hFFFF, e);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1;
    idle();
    rx(REG_STAT, 32'h1 << ST_BUSY, 0);
    run(32'h100, 32'h1234, OP_WRITE);
    run(32'h100, 32'h1230, OP_WRITE);
    rb(32'h100, 32'h1230);
    run(32'h7F000, 32'h00AA, OP_WRITE);
    run(32'h7F000, 0, OP_SETLOCK);
    run(32'h7F000, 0, OP_WRITE);
    rb(32'h7F000, 32'h00AA);
    run(0, 0, OP_CERASE);
    rb(32'h100, 32'hFFFF);
    rb(32'h7F000, 32'h00AA);
    $display("test write and lock done");
    wr(REG_ADDR, 32'h100);
    wr(REG_CTRL, OP_BERASE);
    wr(REG_CTRL, OP_SUSPEND);
    idle();
    rx(REG_STAT, 32'h1 << ST_SUSP, 32'h1 << ST_SUSP);
    run(32'h8000, 32'h0055, OP_WRITE);
    rb(32'h8000, 32'h0055);
    wr(REG_CTRL, OP_RESUME);
    wr(REG_CTRL, OP_CERASE);
    idle();
    rx(REG_STAT, 32'h1 << ST_REFUSED, 32'h1 << ST_REFUSED);
    wr(REG_STAT, 32'h1 << ST_REFUSED);
    supply_low <= 1;
    wr(REG_CTRL, OP_WRITE);
    rx(REG_STAT, 32'h3 << ST_REFUSED, 32'h3 << ST_REFUSED);
    supply_low <= 0;
    $display("test suspend and refusal done");
    run(0, 0, OP_STATUS);
    rx(REG_STAT, 32'h80, 32'h80);
    wr(REG_CTRL, OP_WRITE);
    wr(REG_CTRL, OP_SUSPEND);
    idle();
    rx(REG_STAT, 32'h60000, 32'h60000);
    run(0, 0, OP_RESUME);
    run(32'h7F000, 0, OP_SETPERM);
    run(0, 0, OP_CLRLOCK);
    run(32'h7F000, 0, OP_WRITE);
    rb(32'h7F000, 32'h00AA);
    run(0, 0, OP_RESET);
    rb(32'h8000, 32'h0055);
    $display("test lock and reset done");
    report_and_stop();
  end
endmodule
